// ---- core/hpm_pin_mux.sv ----
/*
  hpm_pin_mux: routes the shared host pins to the non-multiplexed parallel port,
  the multiplexed address/data port or the three-wire serial port, and drives
  the dma request and configurable interrupt pins, and takes in the dma acknowledge pin.
  Assumes all pin inputs are synchronous to clk_i and that the register core
  behind it answers reads on rdata_i and supplies the serial output bit.
*/
// Contract
// - select code 00 non-multiplexed, 01 multiplexed, 10 serial port
// - dma acknowledge is active low, honoured only while dma is enabled
// - dma request raised only while dma is enabled
// - interrupt output selectable active high, active low or open drain
// - interrupt output floats for as long as reset is in effect
// - chip select active low; strobes honoured only while it is low
// - parallel read strobe low makes the device drive the data lines
// - parallel write strobe captures the bus into the device
// - in serial mode the write strobe pin is the shift clock
// - address pin: register select, address latch enable, or serial input
// - lowest data line: data bit, muxed bit, or serial output
// - data lines: plain data bus in mode 0, address then data in mode 1
// - after reset hold clock output 2^14 cycles, no register access then
`timescale 1ns/1ps
`default_nettype none
`include "hpm_params.svh"

module hpm_pin_mux #(
  parameter int unsigned STARTUP_CYCLES = `HPM_STARTUP_CYCLES
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [1:0] interface_select_pins_i,
  input wire logic cs_n_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic register_select_line_i,
  input wire logic [7:0] data_lines_i,
  output logic [7:0] data_lines_o,
  output logic [7:0] data_lines_oe_o,
  input wire logic dma_acknowledge_n_i,
  output logic dma_request_out_o,
  output logic interrupt_out_o,
  output logic interrupt_out_oe_o,
  output logic clock_output_pin_o,
  input wire logic dma_enable_i,
  input wire logic dma_req_i,
  output logic dma_ack_o,
  input wire hpm_pkg::hpm_irq_mode_t irq_mode_i,
  input wire logic irq_i,
  output hpm_pkg::hpm_bus_req_t bus_req_o,
  input wire logic [7:0] rdata_i,
  output hpm_pkg::hpm_ser_bit_t ser_bit_o,
  input wire logic serial_out_i,
  output hpm_pkg::hpm_mode_t mode_o,
  output logic ready_o
);
  import hpm_pkg::*;

  localparam int unsigned CNT_W = `HPM_STARTUP_CNT_W;
  // the count width is fixed by the header; a longer hold needs a wider count there too
  localparam logic [CNT_W-1:0] HOLD_LAST = CNT_W'(STARTUP_CYCLES - 1);

  function automatic hpm_mode_t decode_mode(input logic [1:0] sel);
    hpm_mode_t m;
    m = HPM_MODE_RESERVED;
    if (sel == `HPM_SEL_NONMUX) begin
      m = HPM_MODE_NONMUX;
    end else if (sel == `HPM_SEL_MUX) begin
      m = HPM_MODE_MUX;
    end else if (sel == `HPM_SEL_SERIAL) begin
      m = HPM_MODE_SERIAL;
    end
    return m;
  endfunction

  logic rst_meta;
  logic rst_n;
  logic [CNT_W-1:0] hold_cnt;
  logic ready;
  logic mode_taken;
  hpm_mode_t mode;
  logic wr_q;
  logic rd_q;
  logic cs_q;
  logic ale_q;
  logic [7:0] data_q;
  logic [7:0] addr_latch;
  logic access_ok;
  logic wr_end;
  logic rd_start;
  logic sk_rise;
  logic sk_fall;
  logic ser_take;

  // reset release through two flops
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // startup hold; the register core is unreachable until it ends
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      hold_cnt <= '0;
      ready <= 1'b0;
    end else if (!ready) begin
      if (hold_cnt == HOLD_LAST) begin
        ready <= 1'b1;
      end else begin
        hold_cnt <= hold_cnt + CNT_W'(1);
      end
    end
  end

  // clock output held low during startup, then clk_i / 2
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      clock_output_pin_o <= 1'b0;
    end else begin
      clock_output_pin_o <= ready & ~clock_output_pin_o;
    end
  end

  // straps caught once after release; a later change is ignored on purpose
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      mode_taken <= 1'b0;
      mode <= HPM_MODE_RESERVED;
    end else if (!mode_taken) begin
      mode_taken <= 1'b1;
      mode <= decode_mode(interface_select_pins_i);
    end
  end

  // outputs lag the internal state by one cycle so every pin comes from a flop
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      mode_o <= HPM_MODE_RESERVED;
      ready_o <= 1'b0;
    end else begin
      mode_o <= mode;
      ready_o <= ready & mode_taken;
    end
  end

  // previous pin levels for strobe edges
  // pins are taken as synchronous, so one flop per pin is enough to see an edge
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      wr_q <= 1'b1;
      rd_q <= 1'b1;
      cs_q <= 1'b1;
      ale_q <= 1'b0;
      data_q <= `HPM_DATA_RST;
    end else begin
      wr_q <= wr_n_i;
      rd_q <= rd_n_i;
      cs_q <= cs_n_i;
      ale_q <= register_select_line_i;
      data_q <= data_lines_i;
    end
  end

  // mode 1 address phase: latch follows the bus while the enable is high
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      addr_latch <= `HPM_ADDR_RST;
    end else if (mode == HPM_MODE_MUX && register_select_line_i) begin
      addr_latch <= data_lines_i;
    end
  end

  // the reserved code leaves every strobe dead
  assign access_ok = ready & mode_taken & (mode != HPM_MODE_RESERVED);
  // write data and select are those of the last low cycle of the strobe
  assign wr_end = access_ok & ~wr_q & wr_n_i & ~cs_q;
  assign rd_start = access_ok & rd_q & ~rd_n_i & ~cs_n_i;
  assign sk_rise = access_ok & ~wr_q & wr_n_i & ~cs_n_i;
  assign sk_fall = access_ok & wr_q & ~wr_n_i & ~cs_n_i;
  // a shift edge only counts in serial mode
  assign ser_take = (mode == HPM_MODE_SERIAL) & sk_rise;

  // parallel accesses toward the core
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      bus_req_o <= '0;
    end else begin
      bus_req_o.wr <= 1'b0;
      bus_req_o.rd <= 1'b0;
      unique case (mode)
        HPM_MODE_NONMUX: begin
          bus_req_o.wr <= wr_end;
          bus_req_o.rd <= rd_start;
          if (wr_end || rd_start) begin
            bus_req_o.addr <= {7'h00, wr_end ? ale_q : register_select_line_i};
            bus_req_o.wdata <= data_q;
          end
        end
        HPM_MODE_MUX: begin
          bus_req_o.wr <= wr_end;
          bus_req_o.rd <= rd_start;
          if (wr_end || rd_start) begin
            bus_req_o.addr <= addr_latch;
            bus_req_o.wdata <= data_q;
          end
        end
        HPM_MODE_SERIAL: begin
        end
        HPM_MODE_RESERVED: begin
        end
      endcase
    end
  end

  // serial input bit taken on the shift clock rising edge
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ser_bit_o <= '0;
    end else begin
      ser_bit_o.valid <= ser_take;
      if (ser_take) begin
        ser_bit_o.bit_in <= register_select_line_i;
      end
    end
  end

  // data line drive: read data in parallel modes, serial output in mode 2
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      data_lines_o <= `HPM_DATA_RST;
      data_lines_oe_o <= 8'h00;
    end else begin
      unique case (mode)
        HPM_MODE_NONMUX, HPM_MODE_MUX: begin
          // read data lags the core by one cycle; the core must hold it through the strobe
          data_lines_o <= rdata_i;
          data_lines_oe_o <= {8{access_ok & ~rd_n_i & ~cs_n_i}};
        end
        HPM_MODE_SERIAL: begin
          // output bit changes on the falling shift edge so it is stable at the rise
          if (sk_fall) begin
            data_lines_o <= {7'h00, serial_out_i};
          end
          data_lines_oe_o <= {7'h00, access_ok & ~cs_n_i};
        end
        HPM_MODE_RESERVED: begin
          data_lines_oe_o <= 8'h00;
        end
      endcase
    end
  end

  // dma pins follow the enable, never outside it
  // acknowledge passes on as a level; the core makes any pulse it needs
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      dma_request_out_o <= 1'b0;
      dma_ack_o <= 1'b0;
    end else begin
      dma_request_out_o <= dma_enable_i & dma_req_i & access_ok;
      dma_ack_o <= dma_enable_i & ~dma_acknowledge_n_i;
    end
  end

  // interrupt pin; enable low through the whole reset, so the pin floats
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      interrupt_out_o <= 1'b0;
      interrupt_out_oe_o <= 1'b0;
    end else begin
      case (irq_mode_i)
        HPM_IRQ_HIGH: begin
          interrupt_out_o <= irq_i;
          interrupt_out_oe_o <= 1'b1;
        end
        HPM_IRQ_LOW: begin
          interrupt_out_o <= ~irq_i;
          interrupt_out_oe_o <= 1'b1;
        end
        HPM_IRQ_OPEN_DRAIN: begin
          interrupt_out_o <= 1'b0;
          interrupt_out_oe_o <= irq_i;
        end
        default: begin
          // code 3 floats the pin, as during reset
          interrupt_out_o <= 1'b0;
          interrupt_out_oe_o <= 1'b0;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// ---- include/hpm_params.svh ----
/*
  hpm_params.svh: timing counts and reset values for the host port pin mux.
  Assumes it is included by bare name from the package and the core file.
*/
`ifndef HPM_PARAMS_SVH
`define HPM_PARAMS_SVH

// input clock cycles the clock output is held after reset
`define HPM_STARTUP_CYCLES 16384
`define HPM_STARTUP_CNT_W 15
// interface select pin codes
`define HPM_SEL_NONMUX 2'h0
`define HPM_SEL_MUX 2'h1
`define HPM_SEL_SERIAL 2'h2
// reset values
`define HPM_DATA_RST 8'h00
`define HPM_ADDR_RST 8'h00

`endif

// ---- include/hpm_pkg.sv ----
/*
  hpm_pkg: types shared by the host port pin mux and its surroundings.
  Assumes hpm_params.svh sits on the include path.
*/
`include "hpm_params.svh"

package hpm_pkg;

  typedef enum logic [1:0] {
    HPM_MODE_NONMUX,
    HPM_MODE_MUX,
    HPM_MODE_SERIAL,
    HPM_MODE_RESERVED
  } hpm_mode_t;

  typedef enum logic [1:0] {
    HPM_IRQ_HIGH,
    HPM_IRQ_LOW,
    HPM_IRQ_OPEN_DRAIN
  } hpm_irq_mode_t;

  // one-cycle access toward the register core
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } hpm_bus_req_t;

  // one serial bit taken on a shift clock rising edge
  typedef struct packed {
    logic valid;
    logic bit_in;
  } hpm_ser_bit_t;

endpackage

// ---- tb/host_port_mode_pin_mux_test.sv ----
/*
  host_port_mode_pin_mux_test: self-checking bench for the host pin mux.
  Assumes hpm_pkg and hpm_host_model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module host_port_mode_pin_mux_test;
  import hpm_pkg::*;
  localparam int SU = 8; // short startup hold keeps the run brief
  logic clk_i = 1'b0, nrst_i = 1'b0, dma_enable_i = 1'b0, dma_req_i = 1'b0, dma_acknowledge_n_i = 1'b1;
  logic irq_i = 1'b0, serial_out_i = 1'b0, e_rdy, e_dq, e_dk, e_io, e_ie, e_f;
  logic e_sf, e_so, e_ck, wq = 1'b1;
  logic [7:0] e_oe;
  logic [1:0] interface_select_pins_i = 2'h0;
  logic [7:0] rdata_i = 8'h00, data_lines_i, data_lines_o, data_lines_oe_o, hd, e_rd;
  logic cs_n_i, rd_n_i, wr_n_i, register_select_line_i, dma_request_out_o, interrupt_out_o;
  logic interrupt_out_oe_o, clock_output_pin_o, dma_ack_o, ready_o;
  logic [31:0] r, r2;
  hpm_irq_mode_t irq_mode_i = HPM_IRQ_HIGH;
  hpm_bus_req_t bus_req_o, e, q[$];
  hpm_ser_bit_t ser_bit_o;
  hpm_mode_t mode_o;
  logic sq[$];
  int miscompares = 0, compares = 0, cyc = 0;
  assign data_lines_i = (data_lines_oe_o & data_lines_o) | (~data_lines_oe_o & hd);
  always #50 clk_i = ~clk_i;
  hpm_host_model host (.clk_i, .cs_n_o(cs_n_i), .rd_n_o(rd_n_i), .wr_n_o(wr_n_i),
    .rs_o(register_select_line_i), .d_o(hd));
  hpm_pin_mux #(.STARTUP_CYCLES(SU)) uut (.clk_i, .nrst_i, .interface_select_pins_i, .cs_n_i, .rd_n_i,
    .wr_n_i, .register_select_line_i, .data_lines_i, .data_lines_o, .data_lines_oe_o, .dma_acknowledge_n_i,
    .dma_request_out_o, .interrupt_out_o, .interrupt_out_oe_o, .clock_output_pin_o, .dma_enable_i,
    .dma_req_i, .dma_ack_o, .irq_mode_i, .irq_i, .bus_req_o, .rdata_i, .ser_bit_o, .serial_out_i,
    .mode_o, .ready_o);
  task automatic chk(input logic ok, input string m);
    compares++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask
  task automatic wrap_up();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // expectations from the previous cycle's inputs, then fresh random inputs
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      miscompares++;
      wrap_up();
    end
    e_rdy = ready_o;
    e_dq = dma_enable_i & dma_req_i & (mode_o != HPM_MODE_RESERVED);
    e_dk = dma_enable_i & ~dma_acknowledge_n_i;
    e_f = (irq_mode_i == 2'h3);
    e_io = (irq_mode_i == HPM_IRQ_LOW) ? ~irq_i : (irq_mode_i == HPM_IRQ_HIGH) & irq_i;
    e_ie = (irq_mode_i == HPM_IRQ_OPEN_DRAIN) ? irq_i : !e_f;
    e_rd = rdata_i;
    e_oe = (mode_o == HPM_MODE_SERIAL) ? {7'h00, !cs_n_i}
      : {8{(mode_o != HPM_MODE_RESERVED) && !rd_n_i && !cs_n_i}};
    e_sf = (mode_o == HPM_MODE_SERIAL) && wq && !wr_n_i && !cs_n_i;
    e_so = serial_out_i;
    e_ck = clock_output_pin_o;
    wq = wr_n_i;
    r2 = $urandom;
    dma_enable_i <= r2[0];
    dma_req_i <= r2[1];
    dma_acknowledge_n_i <= !r2[0] | r2[2];
    irq_i <= r2[3] | !nrst_i;
    irq_mode_i <= nrst_i ? hpm_irq_mode_t'(r2[5:4]) : HPM_IRQ_HIGH;
    serial_out_i <= r2[6];
    rdata_i <= r2[15:8];
  end
  always @(negedge clk_i) if (nrst_i) begin
    if (bus_req_o.wr || bus_req_o.rd) begin
      e = q.size() ? q.pop_front() : '0;
      chk(bus_req_o.wr === e.wr && bus_req_o.rd === e.rd && bus_req_o.addr === e.addr
        && (e.rd || bus_req_o.wdata === e.wdata), "access");
    end
    if (ser_bit_o.valid) chk(sq.size() && ser_bit_o.bit_in === sq.pop_front(), "serial");
    if (ready_o && e_rdy) begin
      chk(dma_request_out_o === e_dq && dma_ack_o === e_dk, "dma");
      chk((e_f || interrupt_out_o === e_io) && interrupt_out_oe_o === e_ie, "irq");
      if (data_lines_oe_o === 8'hff) chk(data_lines_o === e_rd, "read data");
      chk(data_lines_oe_o === e_oe, "drive enable");
      if (e_sf) chk(data_lines_o[0] === e_so, "serial out");
      chk(clock_output_pin_o === !e_ck, "clock out");
    end
  end
  // a strobe during the startup hold must be ignored
  task automatic rst(input logic [1:0] m);
    int n;
    n = 0;
    @(posedge clk_i);
    nrst_i <= 1'b0;
    interface_select_pins_i <= m;
    repeat (16) @(posedge clk_i);
    chk(interrupt_out_oe_o === 1'b0, "irq drive in reset");
    nrst_i <= 1'b1;
    fork host.strobe(1'b1, 1'b0, 1'b1, 8'h5a); join_none
    do begin
      @(negedge clk_i);
      n++;
      if (!ready_o) chk(clock_output_pin_o === 1'b0, "clock out in hold");
    end while (!ready_o && n < 64);
    chk(n > SU && n < SU + 6 && mode_o === hpm_mode_t'(m), "startup");
  endtask
  initial begin
    void'($urandom(32'h0aed7364));
    rst(2'h0);
    repeat (20) begin
      r = $urandom;
      q.push_back({r[8], ~r[8], 7'h0, r[9], r[8] ? r[7:0] : 8'h0});
      host.strobe(r[8], 1'b0, r[9], r[7:0]);
    end
    host.strobe(1'b1, 1'b1, 1'b0, 8'h33);
    host.strobe(1'b0, 1'b1, 1'b1, 8'h00);
    rst(2'h1);
    repeat (12) begin
      r = $urandom;
      host.latch(r[15:8]);
      q.push_back({r[16], ~r[16], r[15:8], r[16] ? r[7:0] : 8'h0});
      host.strobe(r[16], 1'b0, 1'b0, r[7:0]);
    end
    rst(2'h2);
    repeat (16) begin
      r = $urandom;
      sq.push_back(r[0]);
      host.strobe(1'b1, 1'b0, r[0], 8'h00);
    end
    rst(2'h3);
    host.strobe(1'b1, 1'b0, 1'b0, 8'ha5);
    host.strobe(1'b0, 1'b0, 1'b0, 8'h00);
    repeat (20) @(posedge clk_i);
    chk(q.size() == 0 && sq.size() == 0, "missing transfers");
    wrap_up();
  end
endmodule
`default_nettype wire

// ---- tb/hpm_host_model.sv ----
/*
  hpm_host_model: cpu side of the host pins, parallel and serial strobes.
  Assumes its tasks are called from the bench's clock domain, one at a time.
*/
`timescale 1ns/1ps
`default_nettype none
module hpm_host_model (
  input wire logic clk_i,
  output logic cs_n_o,
  output logic rd_n_o,
  output logic wr_n_o,
  output logic rs_o,
  output logic [7:0] d_o
);
  initial begin
    cs_n_o = 1'b1;
    rd_n_o = 1'b1;
    wr_n_o = 1'b1;
    rs_o = 1'b0;
    d_o = 8'h00;
  end
  // one strobe low cycle; select and data held until one cycle after the strobe is back high
  task automatic strobe(input logic w, input logic c, input logic r, input logic [7:0] d);
    @(posedge clk_i);
    cs_n_o <= c;
    rs_o <= r;
    d_o <= d;
    if (w) wr_n_o <= 1'b0;
    else rd_n_o <= 1'b0;
    @(posedge clk_i);
    wr_n_o <= 1'b1;
    rd_n_o <= 1'b1;
    @(posedge clk_i);
    cs_n_o <= 1'b1;
    d_o <= ~d; // released bus must not show the old value
  endtask
  task automatic latch(input logic [7:0] a);
    @(posedge clk_i);
    rs_o <= 1'b1;
    d_o <= a;
    @(posedge clk_i);
    rs_o <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ---- tb/hpm_pin_mux_assertions.sv ----
/*
  hpm_pin_mux_assertions: port-level checks of the host pin mux.
  Assumes it is bound to hpm_pin_mux and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
`include "hpm_params.svh"
module hpm_pin_mux_assertions #(
  parameter int unsigned STARTUP_CYCLES = `HPM_STARTUP_CYCLES
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [1:0] interface_select_pins_i,
  input wire logic cs_n_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic register_select_line_i,
  input wire logic [7:0] data_lines_oe_o,
  input wire logic dma_acknowledge_n_i,
  input wire logic dma_request_out_o,
  input wire logic interrupt_out_o,
  input wire logic interrupt_out_oe_o,
  input wire logic dma_enable_i,
  input wire logic irq_i,
  input wire logic dma_ack_o,
  input wire hpm_pkg::hpm_irq_mode_t irq_mode_i,
  input wire hpm_pkg::hpm_bus_req_t bus_req_o,
  input wire hpm_pkg::hpm_ser_bit_t ser_bit_o,
  input wire hpm_pkg::hpm_mode_t mode_o,
  input wire logic ready_o
);
  import hpm_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  logic par;
  assign par = ready_o && (mode_o == HPM_MODE_NONMUX || mode_o == HPM_MODE_MUX);
  property p_mode;
    ready_o |-> mode_o == hpm_mode_t'(interface_select_pins_i) ##1 $stable(mode_o);
  endproperty
  a_mode: assert property (p_mode) else $error("mode differs from strap");
  property p_wr;
    par && $rose(wr_n_i) && !$past(cs_n_i) |=> bus_req_o.wr;
  endproperty
  a_wr: assert property (p_wr) else $error("write not taken");
  property p_rd;
    par && $fell(rd_n_i) && !cs_n_i |=> bus_req_o.rd && data_lines_oe_o == 8'hff;
  endproperty
  a_rd: assert property (p_rd) else $error("read not answered");
  property p_cs;
    cs_n_i && $past(cs_n_i) |=> !bus_req_o.wr && !bus_req_o.rd;
  endproperty
  a_cs: assert property (p_cs) else $error("access without select");
  property p_ser;
    ready_o && mode_o == HPM_MODE_SERIAL && $rose(wr_n_i) && !cs_n_i
      |=> ser_bit_o.valid && ser_bit_o.bit_in == $past(register_select_line_i);
  endproperty
  a_ser: assert property (p_ser) else $error("serial bit lost");
  property p_dreq;
    dma_request_out_o |-> $past(dma_enable_i) && mode_o != HPM_MODE_RESERVED;
  endproperty
  a_dreq: assert property (p_dreq) else $error("dma request while disabled");
  property p_dma_acknowledge_n;
    ready_o |=> dma_ack_o == ($past(dma_enable_i) && !$past(dma_acknowledge_n_i));
  endproperty
  a_dma_acknowledge_n: assert property (p_dma_acknowledge_n) else $error("dma acknowledge wrong");
  property p_irq;
    ready_o && irq_mode_i == HPM_IRQ_OPEN_DRAIN |=> !interrupt_out_o && interrupt_out_oe_o == $past(irq_i);
  endproperty
  a_irq: assert property (p_irq) else $error("open drain interrupt wrong");
endmodule
bind hpm_pin_mux hpm_pin_mux_assertions #(.STARTUP_CYCLES(STARTUP_CYCLES)) u_chk (.clk_i, .nrst_i,
  .interface_select_pins_i, .cs_n_i, .rd_n_i, .wr_n_i, .register_select_line_i, .data_lines_oe_o,
  .dma_acknowledge_n_i, .dma_request_out_o, .interrupt_out_o, .interrupt_out_oe_o, .dma_enable_i,
  .irq_i, .dma_ack_o, .irq_mode_i, .bus_req_o, .ser_bit_o, .mode_o, .ready_o);
`default_nettype wire
